// file: rtl/hmb_cfg.svh
/*
 holds the offsets, field positions and reset values of the
 miscellaneous and buffer status register bank.
 assumes it is included by its bare name before the package and the module.
*/
// What this block does
// - identification word readable only, command 27
// - scratch word, write A8, read 28
// - key F6 resets all registers, not memory
// - soft reset port is write only, A9
// - buffer status read 2C, write AC
// - bit 10 shows active descriptor half
// - bit 9 set when list b read
// - bit 8 set when list a read
// - bits 6,5 show slave host access
// - rising write bit 4 clears selector if async idle
// - bit 3 async list processing, writable
// - bit 2 interrupt list processing, writable
// - bits 1,0 iso lists processing, writable
`ifndef HMB_CFG_SVH
`define HMB_CFG_SVH

// ****************************************************************
// command codes, used as word index; byte address is four times it
// ****************************************************************
`define HMB_CMD_ID_RD      8'h27
`define HMB_CMD_SCR_RD     8'h28
`define HMB_CMD_SCR_WR     8'ha8
`define HMB_CMD_SRST_WR    8'ha9
`define HMB_CMD_STAT_RD    8'h2c
`define HMB_CMD_STAT_WR    8'hac
`define HMB_CMD_IRQ_ST     8'h60
`define HMB_CMD_IRQ_MSK    8'h61

// ****************************************************************
// values
// ****************************************************************
`define HMB_RESET_KEY      16'h00f6
`define HMB_SCR_RESET      16'h0000
`define HMB_ID_DEFAULT     16'h5a01
`define HMB_STAT_WR_MASK   16'h001f
`define HMB_ZERO16         16'h0000
`define HMB_ZERO32         32'h0000_0000
`define HMB_IRQ_BITS       4
`define HMB_BUS_ACK_BIT    1

// ****************************************************************
// buffer status fields
// ****************************************************************
`define HMB_B_HALF         10
`define HMB_B_BDONE        9
`define HMB_B_ADONE        8
`define HMB_B_BACC         6
`define HMB_B_AACC         5
`define HMB_B_CLRSEL       4
`define HMB_B_ASYNC        3
`define HMB_B_INTERRUPT_TRANSFER_LIST         2
`define HMB_B_BPROC        1
`define HMB_B_APROC        0

`endif

// file: rtl/hmb_pkg.sv
/*
 types of the register bank: the wishbone request bundle, the event bundle, the bus state and the state.
 assumes hmb_cfg.svh is on the include path.
*/
`include "hmb_cfg.svh"
package hmb_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [9:0] adr;
        logic [31:0] dat;
    } hmb_wb_req_type;

    typedef struct packed {
        logic [1:0] done;
        logic [1:0] acc;
        logic half_toggle;
        logic half_clear;
    } hmb_evt_type;

    typedef enum logic [1:0] {
        HMB_IDLE = 2'b01,
        HMB_ACK = 2'b10
    } hmb_bus_state_type;

    typedef struct packed {
        hmb_bus_state_type bus;
        logic [31:0] rdat;
        logic [15:0] scratch;
        logic half;
        logic [1:0] done;
        logic [1:0] acc;
        logic clr_last;
        logic [3:0] proc_bits;
        logic [3:0] irq_st;
        logic [3:0] irq_msk;
        logic irq;
        logic srst;
    } hmb_state_type;

endpackage

// file: rtl/hmb_regs.sv
/*
 miscellaneous and buffer status registers of the host controller, reached
 over a classic wishbone slave with 32-bit data; each command code is a word
 index. assumes the transfer engines drive the event inputs on i_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hmb_cfg.svh"
module hmb_regs
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire hmb_pkg::hmb_wb_req_type i_wb,
    input wire hmb_pkg::hmb_evt_type i_evt,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_irq,
    output logic o_soft_reset,
    output logic [3:0] o_list_processing
);
    import hmb_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    localparam logic [15:0] ID_WORD = `HMB_ID_DEFAULT; // arbitrary value

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0])
        begin
            r[7:0] = d[7:0];
        end
        if (sel[1])
        begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    function automatic logic is_cmd(input logic [9:0] adr, input logic [7:0] cmd);
        return adr == {2'b00, cmd};
    endfunction

    hmb_state_type st_r;
    hmb_state_type st_nxt;
    logic [15:0] status_word;
    logic req;
    logic wr;

    // ****************************************************************
    // status word
    // ****************************************************************
    always_comb
    begin
        status_word = `HMB_ZERO16;
        status_word[`HMB_B_HALF] = st_r.half;
        status_word[`HMB_B_BDONE] = st_r.done[1];
        status_word[`HMB_B_ADONE] = st_r.done[0];
        status_word[`HMB_B_BACC] = st_r.acc[1];
        status_word[`HMB_B_AACC] = st_r.acc[0];
        status_word[`HMB_B_CLRSEL] = st_r.clr_last;
        status_word[`HMB_B_ASYNC:`HMB_B_APROC] = st_r.proc_bits;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        logic [15:0] wv;
        logic [3:0] ev;
        wv = `HMB_ZERO16;
        ev = 4'h0;
        st_nxt = st_r;
        req = i_wb.cyc && i_wb.stb && (st_r.bus == HMB_IDLE);
        wr = req && i_wb.we;
        st_nxt.srst = 1'b0;
        // engine events: done flags set by hardware, reading stays sticky
        st_nxt.acc = i_evt.acc;
        st_nxt.done = st_r.done | i_evt.done;
        if (i_evt.half_toggle)
        begin
            st_nxt.half = ~st_r.half;
        end
        if (i_evt.half_clear)
        begin
            st_nxt.done = st_r.done & ~i_evt.done | i_evt.done;
        end
        case (st_r.bus)
            HMB_IDLE:
            begin
                if (req)
                begin
                    st_nxt.bus = HMB_ACK;
                    st_nxt.rdat = `HMB_ZERO32;
                    if (!i_wb.we)
                    begin
                        if (is_cmd(i_wb.adr, `HMB_CMD_ID_RD))
                        begin
                            st_nxt.rdat[15:0] = ID_WORD;
                        end
                        if (is_cmd(i_wb.adr, `HMB_CMD_SCR_RD))
                        begin
                            st_nxt.rdat[15:0] = st_r.scratch;
                        end
                        if (is_cmd(i_wb.adr, `HMB_CMD_STAT_RD))
                        begin
                            st_nxt.rdat[15:0] = status_word;
                        end
                        if (is_cmd(i_wb.adr, `HMB_CMD_IRQ_ST))
                        begin
                            st_nxt.rdat[3:0] = st_r.irq_st;
                        end
                        if (is_cmd(i_wb.adr, `HMB_CMD_IRQ_MSK))
                        begin
                            st_nxt.rdat[3:0] = st_r.irq_msk;
                        end
                    end
                end
            end
            HMB_ACK:
            begin
                st_nxt.bus = HMB_IDLE;
            end
            default:
            begin
                st_nxt.bus = HMB_IDLE;
            end
        endcase
        if (wr && is_cmd(i_wb.adr, `HMB_CMD_SCR_WR))
        begin
            st_nxt.scratch = merge16(st_r.scratch, i_wb.dat, i_wb.sel);
        end
        if (wr && is_cmd(i_wb.adr, `HMB_CMD_STAT_WR))
        begin
            wv = merge16(status_word & `HMB_STAT_WR_MASK, i_wb.dat, i_wb.sel)
                 & `HMB_STAT_WR_MASK;
            st_nxt.proc_bits = wv[`HMB_B_ASYNC:`HMB_B_APROC];
            st_nxt.clr_last = wv[`HMB_B_CLRSEL];
            // a fresh rising write wins over a toggle in the same cycle
            if (wv[`HMB_B_CLRSEL] && !st_r.clr_last && !st_r.proc_bits[`HMB_B_ASYNC])
            begin
                st_nxt.half = 1'b0;
            end
        end
        // interrupt events: done rising edges of each list, access start
        ev[1:0] = i_evt.done & ~st_r.done;
        ev[3:2] = i_evt.acc & ~st_r.acc;
        st_nxt.irq_st = st_r.irq_st;
        if (wr && is_cmd(i_wb.adr, `HMB_CMD_IRQ_ST) && i_wb.sel[0])
        begin
            st_nxt.irq_st = st_r.irq_st & ~i_wb.dat[3:0];
        end
        st_nxt.irq_st = st_nxt.irq_st | ev;
        if (wr && is_cmd(i_wb.adr, `HMB_CMD_IRQ_MSK) && i_wb.sel[0])
        begin
            st_nxt.irq_msk = i_wb.dat[3:0];
        end
        st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_msk);
        // the key only counts on a full low half; other values are ignored
        if (wr && is_cmd(i_wb.adr, `HMB_CMD_SRST_WR) && (&i_wb.sel[1:0])
            && (i_wb.dat[15:0] == `HMB_RESET_KEY))
        begin
            st_nxt.srst = 1'b1;
        end
    end

    // ****************************************************************
    // registers; soft reset keeps the bus answer alive so ack still comes
    // ****************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            st_r <= '0;
            st_r.bus <= HMB_IDLE;
            st_r.scratch <= `HMB_SCR_RESET;
        end
        else if (st_r.srst)
        begin
            st_r <= '0;
            st_r.bus <= st_nxt.bus;
            st_r.rdat <= st_nxt.rdat;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_wb_dat = st_r.rdat;
    // one-hot state: the answer bit is itself a flip-flop, no decode behind the pin
    assign o_wb_ack = st_r.bus[`HMB_BUS_ACK_BIT];
    assign o_irq = st_r.irq;
    assign o_soft_reset = st_r.srst;
    assign o_list_processing = st_r.proc_bits;

endmodule
`default_nettype wire

// file: tb/hmb_regs_props.sv
/*
 port assertions of the register bank.
 assumes a bind onto hmb_regs; one clock, sync reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hmb_cfg.svh"
module hmb_regs_props
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire hmb_pkg::hmb_wb_req_type i_wb,
    input wire hmb_pkg::hmb_evt_type i_evt,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic o_irq,
    input wire logic o_soft_reset,
    input wire logic [3:0] o_list_processing
);
    import hmb_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic rd;
    assign rd = o_wb_ack && !i_wb.we;
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
    ack_prompt_a: assert property ($rose(i_wb.stb) && i_wb.cyc |=> o_wb_ack) else $error("late ack");
    ack_cause_a: assert property (o_wb_ack |-> i_wb.cyc && i_wb.stb) else $error("stray ack");
    id_read_a: assert property (rd && i_wb.adr == 10'h027
        |-> o_wb_dat == {16'h0000, `HMB_ID_DEFAULT}) else $error("bad id word");
    port_read_a: assert property (rd && i_wb.adr == 10'h0a9
        |-> o_wb_dat == 32'h0000_0000) else $error("reset port readable");
    resv_zero_a: assert property (rd && i_wb.adr == 10'h02c
        |-> o_wb_dat[15:11] == 5'h00 && !o_wb_dat[7]) else $error("reserved bits set");
    proc_mirror_a: assert property (rd && i_wb.adr == 10'h02c
        |-> o_wb_dat[3:0] == o_list_processing) else $error("processing bits differ");
    key_effect_a: assert property (o_soft_reset
        |=> !o_soft_reset ##[0:1] o_list_processing == 4'h0) else $error("soft reset weak");
    reset_quiet_a: assert property (disable iff (1'b0) i_rst
        |=> !o_wb_ack && !o_irq && !o_soft_reset) else $error("outputs after reset");
endmodule
`default_nettype wire

// file: tb/hmb_host_model.sv
/*
 host driver model: classic wishbone master, one transfer task.
 assumes callers enter the task just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module hmb_host_model
(
    input wire logic i_clk,
    input wire logic i_ack,
    input wire logic [31:0] i_dat,
    output var hmb_pkg::hmb_wb_req_type o_wb
);
    import hmb_pkg::*;
    initial o_wb = '0;
    // request held until ack or for at most 16 cycles, then one idle cycle before the next
    task automatic xfer(input logic we, input logic [9:0] a, input logic [15:0] d,
        output logic [15:0] r, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        r = 16'h0000;
        o_wb <= '{1'b1, 1'b1, we, 4'h3, a, {16'h0000, d}};
        while (!ok && n < 16)
        begin
            @(posedge i_clk);
            n++;
            ok = i_ack;
            r = i_dat[15:0];
        end
        o_wb <= '0;
        @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

// file: tb/tb_hmb_regs.sv
/*
 bench of the register bank: access table, then events, interrupt,
 selector clear and soft reset. assumes the design and tb files compiled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hmb_cfg.svh"
module tb_hmb_regs;
    import hmb_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    hmb_wb_req_type wb;
    hmb_evt_type evt = '0;
    logic [31:0] dat;
    logic ack, irq, srst, ok;
    logic [3:0] proc;
    logic [15:0] r;
    int bad_count = 0;
    int samples_checked = 0;
    // rows: we, word index, write data, expected read
    logic [42:0] rows [11] = '{{1'b0, 10'h028, 32'h0}, {1'b0, 10'h02c, 32'h0},
        {1'b0, 10'h027, 16'h0, `HMB_ID_DEFAULT}, {1'b1, 10'h0a8, 32'ha5c3_0000},
        {1'b0, 10'h028, 32'h0000_a5c3}, {1'b0, 10'h0a9, 32'h0},
        {1'b1, 10'h0ac, 32'hffff_0000}, {1'b0, 10'h02c, 32'h0000_001f},
        {1'b1, 10'h0ac, 32'h000a_0000}, {1'b0, 10'h02c, 32'h0000_000a},
        {1'b0, 10'h3ff, 32'h0}};
    always #5 i_clk = ~i_clk;
    hmb_regs hmb_regs_i (.i_clk(i_clk), .i_rst(i_rst), .i_wb(wb), .i_evt(evt),
        .o_wb_dat(dat), .o_wb_ack(ack), .o_irq(irq), .o_soft_reset(srst),
        .o_list_processing(proc));
    hmb_host_model hmb_host_model_i (.i_clk(i_clk), .i_ack(ack), .i_dat(dat), .o_wb(wb));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // a missing ack ends the run at once
    task automatic acc(input logic we, input logic [9:0] a, input logic [15:0] d);
        hmb_host_model_i.xfer(we, a, d, r, ok);
        if (!ok)
        begin
            bad_count++;
            finish_test();
        end
    endtask
    // event pulse for one cycle; access levels stay up
    task automatic pulse(input logic [5:0] e);
        evt <= e;
        @(posedge i_clk);
        evt <= e & 6'b001100;
        @(posedge i_clk);
    endtask
    initial
    begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        foreach (rows[k])
        begin
            acc(rows[k][42], rows[k][41:32], rows[k][31:16]);
            if (!rows[k][42])
                chk(r, rows[k][15:0]);
        end
        chk({12'h000, proc}, 16'h000a);
        acc(1'b1, 10'h061, 16'h0000);
        pulse(6'b010000);
        chk({15'h0000, irq}, 16'h0000);
        acc(1'b1, 10'h061, 16'h000f);
        chk({15'h0000, irq}, 16'h0001);
        acc(1'b1, 10'h060, 16'h000f);
        chk({15'h0000, irq}, 16'h0000);
        pulse(6'b101110);
        acc(1'b0, 10'h02c, 16'h0000);
        chk(r, 16'h076a);
        acc(1'b1, 10'h0ac, 16'h0008);
        acc(1'b1, 10'h0ac, 16'h0018);
        acc(1'b0, 10'h02c, 16'h0000);
        chk(r, 16'h0778);
        acc(1'b1, 10'h0ac, 16'h0000);
        acc(1'b1, 10'h0ac, 16'h0010);
        acc(1'b0, 10'h02c, 16'h0000);
        chk(r, 16'h0370);
        evt <= '0;
        acc(1'b1, 10'h0a8, 16'h1234);
        acc(1'b1, 10'h0a9, 16'h00f5);
        acc(1'b0, 10'h028, 16'h0000);
        chk(r, 16'h1234);
        acc(1'b1, 10'h0a9, 16'h00f6);
        acc(1'b0, 10'h028, 16'h0000);
        chk(r, 16'h0000);
        acc(1'b0, 10'h02c, 16'h0000);
        chk(r, 16'h0000);
        finish_test();
    end
endmodule
bind hmb_regs hmb_regs_props hmb_regs_props_i (.i_clk(i_clk), .i_rst(i_rst), .i_wb(i_wb),
    .i_evt(i_evt), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_irq(o_irq),
    .o_soft_reset(o_soft_reset), .o_list_processing(o_list_processing));
`default_nettype wire
